// File: hdl/fml_pkg.sv
// Purpose: shared constants and types for the flash mode, lock and reset
//          command interpreter.
// Assumes: 100 MHz system clock; opcodes framed by chip select.
// Notes:   one lock bit per 64 KB block; the index comes from the address.
package fml_pkg;

  // opcodes
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_ENTER   = 8'h38;
  localparam logic [7:0] OP_EXIT    = 8'hFF;
  localparam logic [7:0] OP_LOCK    = 8'h36;
  localparam logic [7:0] OP_UNLOCK  = 8'h39;
  localparam logic [7:0] OP_RDLOCK  = 8'h3D;
  localparam logic [7:0] OP_GLOCK   = 8'h7E;
  localparam logic [7:0] OP_GUNLOCK = 8'h98;
  localparam logic [7:0] OP_RSTEN   = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_SETPAR  = 8'hC0;
  localparam logic [7:0] OP_WRAPRD  = 8'h0C;
  localparam logic [7:0] OP_FASTRD  = 8'h0B;

  // bit counts at which frame fields are complete
  localparam logic [6:0] CNT_OP    = 7'h08;
  localparam logic [6:0] CNT_PARAM = 7'h10;
  localparam logic [6:0] CNT_ADDR  = 7'h20;
  localparam logic [6:0] CNT_MAX   = 7'h7F;

  // lock array layout
  localparam int unsigned LOCK_N     = 256;
  localparam int unsigned LOCK_SHIFT = 16;
  localparam int unsigned LOCK_IW    = 8;

  // read parameter fields and reset values
  localparam int unsigned PAR_DUMMY_LSB = 4;
  localparam int unsigned PAR_WRAP_LSB  = 0;
  localparam logic [7:0]  PARAM_RST     = 8'h00;
  localparam logic [23:0] WRAP_BASE     = 24'h000008;

  // reset recovery time
  localparam int unsigned CLK_NS  = 10;
  localparam int unsigned RST_NS  = 30000;
  localparam int unsigned RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BUSY_W  = 12;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  data;
    logic [23:0] addr;
    logic [6:0]  nbits;
  } fml_frame_t;

endpackage

// File: hdl/fml_cmd.sv
// Purpose: command interpreter for mode switch, block locks and soft reset
// Assumes: chip select high time covers at least 8 system clocks, so the
//          system side has finished with a frame before the next starts.
// Notes:   mode, read parameters and lock bits change only while chip
//          select is high, so the link logic reads them as static levels.
`timescale 1ns/1ps

// Notes on behaviour
// RL1 - wrapped burst read in quad command mode wraps inside its window
// RL2 - wrap length and dummy clocks come from the read parameter bits
// RL3 - only one mode at a time; entry opcode is the only way in
// RL4 - power-up starts in the single, dual or quad serial mode
// RL5 - entry opcode ignored unless the quad enable bit is set
// RL6 - entering quad command mode keeps write latch, suspend and wrap
// RL7 - exit opcode in quad command mode returns to serial mode
// RL8 - leaving quad command mode keeps write latch, suspend and wrap
// RL9 - entry opcode only accepted in serial mode
// RL10 - exit opcode only accepted in quad command mode
// RL11 - lock bits protect only when lock scheme select is one
// RL12 - lock bits are volatile and set to one at power-up and reset
// RL13 - lock opcode plus 24-bit address sets the addressed lock bit
// RL14 - unlock opcode plus 24-bit address clears the addressed lock bit
// RL15 - lock commands need the write latch flag set first
// RL16 - lock read-back shifts a byte out, MSB first, on falling edges
// RL17 - read-back LSB one means locked, zero means unlocked
// RL18 - global lock opcode alone sets every lock bit
// RL19 - global unlock opcode alone clears every lock bit
// RL20 - accepted reset restores power-on defaults of volatile state
// RL21 - reset needs reset-enable directly before; anything else disarms
// RL22 - every command rejected for 30 us after an accepted reset
// RL23 - host should check busy and suspend before resetting
// RL24 - wrap length 8, 16, 32 or 64 bytes; default 8
// RL25 - lock commands without write latch flag change nothing
module fml_cmd (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  output logic      [23:0] mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  input  wire logic        quad_enable_bit_i,
  input  wire logic        lock_scheme_select_i,
  input  wire logic        legacy_protect_i,
  input  wire logic [23:0] prot_addr_i,
  output logic             prot_locked_o,
  output logic             quad_command_mode_o,
  output logic             write_latch_flag_o,
  output logic      [7:0]  read_param_bits_o,
  output logic             busy_o,
  output logic             soft_reset_o
);

  // ---- link side: frame capture on rising serial clock
  fml_pkg::fml_frame_t fr_q;
  fml_pkg::fml_frame_t fr_d;
  logic [31:0] sh_q;
  logic [31:0] sh_d;
  logic        start_q;
  logic        ftgl_q;
  logic [2:0]  lbusy_q;
  logic        lbusy_l_q;
  logic        qpi_q;
  logic [7:0]  rpar_q;
  logic [fml_pkg::LOCK_N-1:0] lock_q;

  // start flag is raised by chip select itself so no edge is needed
  // outside a frame
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge rstn_i)
  begin
    if (!rstn_i)
      start_q <= 1'b1;
    else if (cs_n_i)
      start_q <= 1'b1;
    else
      start_q <= 1'b0;
  end

  always_comb
  begin
    logic [6:0] cnt_n;
    logic [7:0] sum;
    cnt_n = start_q ? 7'h00 : fr_q.nbits;
    sum   = 8'h00;
    fr_d  = fr_q;
    if (qpi_q)
    begin
      sh_d = {sh_q[27:0], io_i};
      sum  = {1'b0, cnt_n} + 8'h04;
    end
    else
    begin
      sh_d = {sh_q[30:0], io_i[0]};
      sum  = {1'b0, cnt_n} + 8'h01;
    end
    fr_d.nbits = (sum > {1'b0, fml_pkg::CNT_MAX}) ? fml_pkg::CNT_MAX
                                                  : sum[6:0];
    if (fr_d.nbits == fml_pkg::CNT_OP)
      fr_d.op = sh_d[7:0];
    if (fr_d.nbits == fml_pkg::CNT_PARAM)
      fr_d.data = sh_d[7:0];
    if (fr_d.nbits == fml_pkg::CNT_ADDR)
      fr_d.addr = sh_d[23:0];
  end

  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fr_q <= '0;
      sh_q <= 32'h0000_0000;
    end
    else
    begin
      fr_q <= fr_d;
      sh_q <= sh_d;
    end
  end

  // one toggle per clocked frame tells the system side a frame happened
  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ftgl_q <= 1'b0;
    else if (start_q)
      ftgl_q <= ~ftgl_q;
  end

  // busy crosses into the link domain through three flops
  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lbusy_q   <= 3'h0;
      lbusy_l_q <= 1'b0;
    end
    else
    begin
      lbusy_q <= {lbusy_q[1:0], busy_o};
      if (lbusy_q[1] == lbusy_q[2])
        lbusy_l_q <= lbusy_q[2];
    end
  end

  // ---- link side: read data out on falling serial clock
  logic [7:0]  out_q;
  logic        oe_q;
  logic        nib_q;
  logic [23:0] rd_addr_q;
  logic        is_rdlock;
  logic        is_read;
  logic        is_wrap;
  logic [6:0]  dstart;
  logic [23:0] wmask;
  logic [23:0] rd_next;
  logic        lock_sel;

  assign is_rdlock = (fr_q.op == fml_pkg::OP_RDLOCK);
  assign is_wrap   = qpi_q && (fr_q.op == fml_pkg::OP_WRAPRD);
  assign is_read   = is_wrap || (qpi_q && fr_q.op == fml_pkg::OP_FASTRD);
  // dummy clocks 2,4,6,8 at four bits each after the address
  assign dstart    = fml_pkg::CNT_ADDR
                   + {1'b0, ({1'b0, rpar_q[fml_pkg::PAR_DUMMY_LSB +: 2]}
                             + 3'h1), 3'b000};                  // [RL2]
  assign wmask     = (fml_pkg::WRAP_BASE
                      << rpar_q[fml_pkg::PAR_WRAP_LSB +: 2])
                   - 24'h000001;                        // [RL2] [RL24]
  assign rd_next   = is_wrap ? ((rd_addr_q & ~wmask)
                                | ((rd_addr_q + 24'h000001) & wmask))
                             : rd_addr_q + 24'h000001;          // [RL1]
  assign lock_sel  = lock_q[fr_q.addr[fml_pkg::LOCK_SHIFT +:
                                      fml_pkg::LOCK_IW]];

  always_ff @(negedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_q     <= 8'h00;
      oe_q      <= 1'b0;
      nib_q     <= 1'b0;
      rd_addr_q <= 24'h000000;
    end
    else if (lbusy_l_q)
      oe_q <= 1'b0;                                             // [RL22]
    else if (is_rdlock && fr_q.nbits == fml_pkg::CNT_ADDR)
    begin
      out_q <= {7'h00, lock_sel};                        // [RL16] [RL17]
      oe_q  <= 1'b1;
    end
    else if (is_read && fr_q.nbits == fml_pkg::CNT_ADDR)
    begin
      rd_addr_q <= fr_q.addr;
      oe_q      <= 1'b0;
    end
    else if (fr_q.nbits <= fml_pkg::CNT_ADDR)
      oe_q <= 1'b0;
    else if (is_read && fr_q.nbits == dstart)
    begin
      out_q     <= mem_data_i;
      nib_q     <= 1'b1;
      oe_q      <= 1'b1;
      rd_addr_q <= rd_next;
    end
    else if (is_read && fr_q.nbits > dstart && !nib_q)
    begin
      out_q     <= mem_data_i;
      nib_q     <= 1'b1;
      rd_addr_q <= rd_next;                                     // [RL1]
    end
    else if (oe_q)
    begin
      nib_q <= 1'b0;
      out_q <= qpi_q ? {out_q[3:0], 4'h0}
                     : {out_q[6:0], 1'b0};                      // [RL16]
    end
  end

  assign io_o       = qpi_q ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
  // an enable left over from the last read must not fight the host while
  // it shifts the first bits of the next frame
  assign io_oe_o    = (oe_q && !cs_n_i && !start_q
                       && fr_q.nbits >= fml_pkg::CNT_ADDR)
                    ? (qpi_q ? 4'hF : 4'h2) : 4'h0;
  assign mem_addr_o = rd_addr_q;

  // ---- system side: frame end detection
  logic [2:0] cs_s_q;
  logic       cs_l_q;
  logic [2:0] tg_s_q;
  logic       tg_l_q;
  logic       tg_seen_q;
  logic       cs_rise;
  logic       exec;
  logic       len8;
  logic       len16;
  logic       len32;
  logic       wel_q;
  logic       armed_q;
  logic       rst_take;
  logic       rst_pulse_q;
  logic [fml_pkg::BUSY_W-1:0] busy_cnt_q;
  logic       lock_ok;
  logic       op_lock;
  logic       op_unlock;
  logic       op_glock;
  logic       op_gunlock;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cs_s_q <= 3'h7;
      cs_l_q <= 1'b1;
      tg_s_q <= 3'h0;
      tg_l_q <= 1'b0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[1:0], cs_n_i};
      tg_s_q <= {tg_s_q[1:0], ftgl_q};
      if (cs_s_q[1] == cs_s_q[2])
        cs_l_q <= cs_s_q[2];
      if (tg_s_q[1] == tg_s_q[2])
        tg_l_q <= tg_s_q[2];
    end
  end

  assign cs_rise = !cs_l_q && cs_s_q[1] && cs_s_q[2];

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tg_seen_q <= 1'b0;
    else if (cs_rise)
      tg_seen_q <= tg_l_q;
  end

  // frame data is still because the serial clock stops with chip select
  assign exec  = cs_rise && (tg_l_q != tg_seen_q) && !busy_o;   // [RL22]
  assign len8  = (fr_q.nbits == fml_pkg::CNT_OP);
  assign len16 = (fr_q.nbits == fml_pkg::CNT_PARAM);
  assign len32 = (fr_q.nbits == fml_pkg::CNT_ADDR);

  // ---- reset sequence
  assign rst_take = exec && armed_q && len8
                 && fr_q.op == fml_pkg::OP_RST;                 // [RL21]

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      armed_q <= 1'b0;
    else if (exec)
      armed_q <= len8 && fr_q.op == fml_pkg::OP_RSTEN;          // [RL21]
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_cnt_q <= '0;
    else if (rst_take)
      busy_cnt_q <= fml_pkg::BUSY_W'(fml_pkg::RST_CYC);         // [RL22]
    else if (busy_cnt_q != '0)
      busy_cnt_q <= busy_cnt_q - 1'b1;
  end

  assign busy_o = (busy_cnt_q != '0);

  // other blocks clear their own volatile status, suspend, continuous
  // read and wrap setting bits from this pulse
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_pulse_q <= 1'b0;
    else
      rst_pulse_q <= rst_take;                                  // [RL20]
  end

  assign soft_reset_o = rst_pulse_q;

  // ---- mode; switching leaves write latch and parameters alone
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      qpi_q <= 1'b0;                                            // [RL4]
    else if (rst_take)
      qpi_q <= 1'b0;                                            // [RL20]
    else if (exec && len8 && !qpi_q && quad_enable_bit_i
             && fr_q.op == fml_pkg::OP_ENTER)
      qpi_q <= 1'b1;                            // [RL3] [RL5] [RL6] [RL9]
    else if (exec && len8 && qpi_q && fr_q.op == fml_pkg::OP_EXIT)
      qpi_q <= 1'b0;                                   // [RL7] [RL8] [RL10]
  end

  // ---- write latch and read parameters
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wel_q <= 1'b0;
    else if (rst_take)
      wel_q <= 1'b0;                                            // [RL20]
    else if (exec && len8 && fr_q.op == fml_pkg::OP_WREN)
      wel_q <= 1'b1;
    else if (exec && len8 && fr_q.op == fml_pkg::OP_WRDI)
      wel_q <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rpar_q <= fml_pkg::PARAM_RST;                             // [RL24]
    else if (rst_take)
      rpar_q <= fml_pkg::PARAM_RST;                             // [RL20]
    else if (exec && len16 && qpi_q && fr_q.op == fml_pkg::OP_SETPAR)
      rpar_q <= fr_q.data;                                      // [RL2]
  end

  // ---- lock array
  assign lock_ok    = exec && wel_q;                     // [RL15] [RL25]
  assign op_lock    = lock_ok && len32 && fr_q.op == fml_pkg::OP_LOCK;
  assign op_unlock  = lock_ok && len32 && fr_q.op == fml_pkg::OP_UNLOCK;
  assign op_glock   = lock_ok && len8 && fr_q.op == fml_pkg::OP_GLOCK;
  assign op_gunlock = lock_ok && len8 && fr_q.op == fml_pkg::OP_GUNLOCK;

  for (genvar i = 0; i < fml_pkg::LOCK_N; i++)
  begin : g_lock
    logic hit;
    assign hit = (fr_q.addr[fml_pkg::LOCK_SHIFT +: fml_pkg::LOCK_IW]
                  == fml_pkg::LOCK_IW'(i));
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
      if (!rstn_i)
        lock_q[i] <= 1'b1;                                      // [RL12]
      else if (rst_take || op_glock)
        lock_q[i] <= 1'b1;                              // [RL12] [RL18]
      else if (op_gunlock)
        lock_q[i] <= 1'b0;                                      // [RL19]
      else if (op_lock && hit)
        lock_q[i] <= 1'b1;                                      // [RL13]
      else if (op_unlock && hit)
        lock_q[i] <= 1'b0;                                      // [RL14]
    end
  end

  // ---- protection answer for the erase and program engine
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prot_locked_o <= 1'b1;
    else if (lock_scheme_select_i)
      prot_locked_o <= lock_q[prot_addr_i[fml_pkg::LOCK_SHIFT +:
                                          fml_pkg::LOCK_IW]];   // [RL11]
    else
      prot_locked_o <= legacy_protect_i;                        // [RL11]
  end

  assign quad_command_mode_o = qpi_q;
  assign write_latch_flag_o  = wel_q;
  assign read_param_bits_o   = rpar_q;

  // ---- checks
  sequence s_reset_taken;
    exec && armed_q && len8 && fr_q.op == fml_pkg::OP_RST;
  endsequence

  property p_reset_defaults;
    @(posedge clock_i) disable iff (!rstn_i)
    s_reset_taken |=> busy_o && !qpi_q && !wel_q && (&lock_q)
                      && rpar_q == fml_pkg::PARAM_RST && soft_reset_o;
  endproperty

  a_reset_defaults: assert property (p_reset_defaults) // [RL12] [RL20]
    else $error("reset did not restore defaults");

  a_reset_armed: assert property ( // [RL21]
    @(posedge clock_i) disable iff (!rstn_i)
    $rose(busy_o) |-> $past(armed_q))
    else $error("reset taken without reset enable");

  a_busy_hold: assert property ( // [RL22]
    @(posedge clock_i) disable iff (!rstn_i)
    $rose(busy_o) |-> busy_o [*8] ##0 (busy_cnt_q ==
      fml_pkg::BUSY_W'(fml_pkg::RST_CYC - 7)))
    else $error("reset busy window too short");

  a_busy_reject: assert property ( // [RL22]
    @(posedge clock_i) disable iff (!rstn_i)
    busy_o && !rst_take |=> $stable(lock_q) && $stable(qpi_q)
                           && $stable(wel_q))
    else $error("command taken while busy");

  a_enter_qe: assert property ( // [RL5]
    @(posedge clock_i) disable iff (!rstn_i)
    $rose(qpi_q) |-> $past(quad_enable_bit_i) && $past(exec)
                     && $past(fr_q.op) == fml_pkg::OP_ENTER)
    else $error("quad command mode entered without quad enable");

  a_exit_mode: assert property ( // [RL7]
    @(posedge clock_i) disable iff (!rstn_i)
    exec && len8 && qpi_q && fr_q.op == fml_pkg::OP_EXIT |=> !qpi_q)
    else $error("exit opcode did not leave quad command mode");

  a_mode_keeps: assert property ( // [RL6] [RL8]
    @(posedge clock_i) disable iff (!rstn_i)
    $changed(qpi_q) && !$past(rst_take) |-> $stable(wel_q)
                                          && $stable(rpar_q))
    else $error("mode switch disturbed write latch or parameters");

  a_lock_wel: assert property ( // [RL15] [RL25]
    @(posedge clock_i) disable iff (!rstn_i)
    !$stable(lock_q) && !$past(rst_take) |-> $past(wel_q))
    else $error("lock bits changed without write latch flag");

  a_glock_all: assert property ( // [RL18]
    @(posedge clock_i) disable iff (!rstn_i)
    op_glock |=> (&lock_q))
    else $error("global lock left a bit clear");

  a_gunlock_all: assert property ( // [RL19]
    @(posedge clock_i) disable iff (!rstn_i)
    op_gunlock |=> lock_q == '0)
    else $error("global unlock left a bit set");

  a_wrap_window: assert property ( // [RL1]
    @(negedge sclk_i) disable iff (!rstn_i || cs_n_i)
    is_wrap && fr_q.nbits > dstart |=> rd_addr_q[23:6] ==
                                        $past(rd_addr_q[23:6]))
    else $error("wrapped read left its window");

endmodule

// File: tb/fml_host_model.sv
// Purpose: host serial controller driving chip select, clock and data
// Assumes: 80 ns link clock, idle low, running only inside frames
// Notes:   undriven device lines read back as unknown so they never match
`timescale 1ns/1ps
module fml_host_model (
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic      [3:0] io_o,
  input  wire logic [3:0] io_i,
  input  wire logic [3:0] io_oe_i
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o   = 4'h5;
  end

  // n bits MSB first, then nr read clocks sampled on the rise
  task automatic frame(input logic [31:0] v, input int n, input bit q,
                       input int nr, output logic [31:0] rd);
    int         k;
    logic [3:0] s;
    rd = '0;
    #3 cs_n_o = 1'b0;
    for (k = 0; k < n; k += (q ? 4 : 1))
    begin
      io_o = q ? v[31-k -: 4] : {3'h0, v[31-k]};
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    // a released line shows the inverse, not the stale value
    io_o = ~io_o;
    for (k = 0; k < nr; k++)
    begin
      #40 sclk_o = 1'b1;
      if (q)
        s = (io_oe_i === 4'hF) ? io_i : 4'hX;
      else
        s = {3'h0, (io_oe_i[1] === 1'b1) ? io_i[1] : 1'bx};
      rd = q ? {rd[27:0], s} : {rd[30:0], s[0]};
      #40 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    #200;
  endtask
endmodule

// File: tb/fml_cmd_tb_top.sv
// Purpose: self-checking bench for the mode, lock and reset interpreter
// Assumes: host model speaks the link; system inputs driven on clock_i
// Notes:   array data is the address xor a pattern, so wraps are visible
`timescale 1ns/1ps
module fml_cmd_tb_top;
  logic        clock_i;
  logic        rstn_i;
  logic        qeb;
  logic        lss;
  logic        lgp;
  logic [23:0] pa;
  wire         cs_n;
  wire         sclk;
  wire  [3:0]  hio;
  wire  [3:0]  dio;
  wire  [3:0]  doe;
  wire  [23:0] maddr;
  wire  [7:0]  mdat;
  wire  [7:0]  rpb;
  wire         plk;
  wire         qcm;
  wire         write_latch_flag;
  wire         bsy;
  wire         srst;
  logic [31:0] rd;
  bit          q;
  int          n_fail;
  int          tests_run;
  int          n_srst;
  int          n_busy;
  int          cyc;
  int          i;

  assign mdat = maddr[7:0] ^ 8'h5A;

  fml_cmd uut (
    .clock_i              (clock_i),
    .rstn_i               (rstn_i),
    .sclk_i               (sclk),
    .cs_n_i               (cs_n),
    .io_i                 (hio),
    .io_o                 (dio),
    .io_oe_o              (doe),
    .mem_addr_o           (maddr),
    .mem_data_i           (mdat),
    .quad_enable_bit_i    (qeb),
    .lock_scheme_select_i (lss),
    .legacy_protect_i     (lgp),
    .prot_addr_i          (pa),
    .prot_locked_o        (plk),
    .quad_command_mode_o  (qcm),
    .write_latch_flag_o   (write_latch_flag),
    .read_param_bits_o    (rpb),
    .busy_o               (bsy),
    .soft_reset_o         (srst)
  );

  fml_host_model host (
    .cs_n_o  (cs_n),
    .sclk_o  (sclk),
    .io_o    (hio),
    .io_i    (dio),
    .io_oe_i (doe)
  );

  initial
  begin
    clock_i = 1'b0;
    rstn_i  = 1'b0;
    qeb     = 1'b0;
    lss     = 1'b1;
    lgp     = 1'b0;
    pa      = 24'h120000;
    q       = 1'b0;
  end

  always #5 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    cyc++;
    if (srst === 1'b1)
      n_srst++;
    if (bsy === 1'b1)
      n_busy++;
    if (cyc == 60000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input int n);
    host.frame({op, a}, n, q, 0, rd);
  endtask

  task automatic rdlock(input logic [23:0] a, input logic [7:0] e);
    host.frame({fml_pkg::OP_RDLOCK, a}, 32, q, q ? 2 : 8, rd);
    check("lock byte", {24'h0, rd[7:0]}, {24'h0, e});
  endtask

  task automatic sys(input logic s, input logic l);
    @(posedge clock_i);
    lss <= s;
    lgp <= l;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  initial
  begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    check("mode", qcm, 1'b0);
    check("param", rpb, 8'h00);
    check("prot", plk, 1'b1);
    rdlock(24'h120000, 8'h01);
    cmd(fml_pkg::OP_UNLOCK, 24'h120000, 32);
    rdlock(24'h120000, 8'h01);
    cmd(fml_pkg::OP_WREN, 24'h0, 8);
    check("latch", write_latch_flag, 1'b1);
    cmd(fml_pkg::OP_UNLOCK, 24'h120000, 32);
    rdlock(24'h120000, 8'h00);
    check("prot", plk, 1'b0);
    sys(1'b0, 1'b1);
    check("prot", plk, 1'b1);
    sys(1'b1, 1'b0);
    cmd(fml_pkg::OP_GLOCK, 24'h0, 8);
    rdlock(24'h120000, 8'h01);
    cmd(fml_pkg::OP_GUNLOCK, 24'h0, 8);
    rdlock(24'h400000, 8'h00);
    cmd(fml_pkg::OP_LOCK, 24'h400000, 32);
    rdlock(24'h400000, 8'h01);
    cmd(fml_pkg::OP_ENTER, 24'h0, 8);
    check("mode", qcm, 1'b0);
    cmd(fml_pkg::OP_EXIT, 24'h0, 8);
    check("mode", qcm, 1'b0);
    @(posedge clock_i);
    qeb <= 1'b1;
    cmd(fml_pkg::OP_ENTER, 24'h0, 8);
    check("mode", qcm, 1'b1);
    check("latch", write_latch_flag, 1'b1);
    q = 1'b1;
    cmd(fml_pkg::OP_ENTER, 24'h0, 8);
    check("mode", qcm, 1'b1);
    cmd(fml_pkg::OP_SETPAR, 24'h110000, 16);
    check("param", rpb, 8'h11);
    // 4 dummy clocks, 16-byte window from 1E: 1E, 1F, then back to 10, 11
    host.frame({fml_pkg::OP_WRAPRD, 24'h00011E}, 32, 1'b1, 12, rd);
    check("wrap data", rd, {8'h1E ^ 8'h5A, 8'h1F ^ 8'h5A,
                            8'h10 ^ 8'h5A, 8'h11 ^ 8'h5A});
    // the plain fast read runs on past the window edge
    host.frame({fml_pkg::OP_FASTRD, 24'h00011E}, 32, 1'b1, 12, rd);
    check("fast data", rd, {8'h1E ^ 8'h5A, 8'h1F ^ 8'h5A,
                            8'h20 ^ 8'h5A, 8'h21 ^ 8'h5A});
    rdlock(24'h400000, 8'h01);
    cmd(fml_pkg::OP_EXIT, 24'h0, 8);
    q = 1'b0;
    check("mode", qcm, 1'b0);
    check("latch", write_latch_flag, 1'b1);
    check("param", rpb, 8'h11);
    check("busy", bsy, 1'b0);
    cmd(fml_pkg::OP_RSTEN, 24'h0, 8);
    rdlock(24'h400000, 8'h01);
    cmd(fml_pkg::OP_RST, 24'h0, 8);
    check("busy", bsy, 1'b0);
    check("pulses", n_srst, 0);
    cmd(fml_pkg::OP_ENTER, 24'h0, 8);
    q = 1'b1;
    cmd(fml_pkg::OP_SETPAR, 24'h020000, 16);
    cmd(fml_pkg::OP_RSTEN, 24'h0, 8);
    cmd(fml_pkg::OP_RST, 24'h0, 8);
    q = 1'b0;
    check("busy", bsy, 1'b1);
    cmd(fml_pkg::OP_WREN, 24'h0, 8);
    for (i = 0; i < 4000 && bsy !== 1'b0; i++)
      @(posedge clock_i);
    repeat (4) @(posedge clock_i);
    check("busy", bsy, 1'b0);
    check("busy cycles", n_busy, fml_pkg::RST_CYC);
    check("latch", write_latch_flag, 1'b0);
    check("mode", qcm, 1'b0);
    check("param", rpb, 8'h00);
    check("pulses", n_srst, 1);
    rdlock(24'h120000, 8'h01);
    cmd(fml_pkg::OP_GUNLOCK, 24'h0, 8);
    rdlock(24'h120000, 8'h01);
    cmd(fml_pkg::OP_WREN, 24'h0, 8);
    check("latch", write_latch_flag, 1'b1);
    cmd(fml_pkg::OP_WRDI, 24'h0, 8);
    check("latch", write_latch_flag, 1'b0);
    summarize();
  end
endmodule
